/* sim/osc_and_system_clock_gating_tb_top.sv */
// Purpose: Self-checking bench for the oscillator and clock gating block.
// Assumes: Timeouts are shortened by parameters; APB answers with zero wait states.
// Notes:   Event inputs are pulsed one cycle through a shared mask vector.
`define CHK(nm, exp, got) begin checks++; if ((got) !== (exp)) begin error_cnt++; \
   $display("[FAIL] %s expected %0h seen %0h", nm, (exp), (got)); end end
module osc_and_system_clock_gating_tb_top
   import oscg_pkg::*;
;
   timeunit 1ns;
   timeprecision 1ns;

   localparam int P_POR = 8;
   localparam int P_LONG = 20;
   localparam int P_SHORT = 6;
   localparam logic [4:0] EV_WAIT = 5'h10;
   localparam logic [4:0] EV_STOP = 5'h08;
   localparam logic [4:0] EV_WAKE = 5'h04;
   localparam logic [4:0] EV_IRST = 5'h02;
   localparam logic [4:0] EV_XRST = 5'h01;

   logic        sys_clk, srst, cfg_short, psel, penable, pwrite, e, por;
   logic        quad_rate_clock, double_rate_clock, cpu_clock, periph_clock;
   logic        aux_clock_pin_out, aux_clock_pin_oe, port_bit_four_sel, pready, pslverr;
   logic [1:0]  cfg_src, clock_source_active;
   logic [4:0]  evt;
   logic [11:0] paddr;
   logic [31:0] pwdata, prdata, d, a, b;
   int          checks = 0, error_cnt = 0, c0, c, p, q, n, s;
   int          cpu_edges, per_edges, quad_edges;

   oscg_clock_gating #(.POR_QUAD_CYCLES(P_POR), .STOP_LONG_CYCLES(P_LONG),
      .STOP_SHORT_CYCLES(P_SHORT)) dut_u (
      .sys_clk(sys_clk), .srst(srst), .cfg_clock_source(cfg_src),
      .cfg_stop_short_delay(cfg_short), .por_reset(por), .internal_reset(evt[1]),
      .ext_reset_pin(evt[0]), .wait_req(evt[4]), .stop_req(evt[3]), .wake_irq(evt[2]),
      .quad_rate_clock(quad_rate_clock), .double_rate_clock(double_rate_clock),
      .cpu_clock(cpu_clock), .periph_clock(periph_clock),
      .clock_source_active(clock_source_active), .aux_clock_pin_out(aux_clock_pin_out),
      .aux_clock_pin_oe(aux_clock_pin_oe), .port_bit_four_sel(port_bit_four_sel),
      .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
      .prdata(prdata), .pready(pready), .pslverr(pslverr));

   oscg_far_side far_u (.sys_clk(sys_clk), .cpu_clock(cpu_clock),
      .periph_clock(periph_clock), .quad_rate_clock(quad_rate_clock),
      .cpu_edges(cpu_edges), .per_edges(per_edges), .quad_edges(quad_edges));

   initial
   begin
      sys_clk = 1'b0;
      forever #50 sys_clk = ~sys_clk;
   end

   task complete_run;
      $display("checks %0d errors %0d", checks, error_cnt);
      if (error_cnt == 0 && checks > 0)
         $display("DONE - PASS");
      else
         $display("DONE - FAIL");
      $finish;
   endtask

   task apb(input logic wr, input logic [11:0] ad, input logic [31:0] wd,
            output logic [31:0] rd, output logic err);
      int k;
      @(posedge sys_clk);
      psel    <= 1'b1;
      penable <= 1'b0;
      pwrite  <= wr;
      paddr   <= ad;
      pwdata  <= wd;
      @(posedge sys_clk);
      penable <= 1'b1;
      k = 0;
      do
      begin
         @(posedge sys_clk);
         k++;
      end
      while (pready !== 1'b1 && k < 16);
      if (pready !== 1'b1)
         error_cnt++;
      rd = prdata;
      err = pslverr;
      psel    <= 1'b0;
      penable <= 1'b0;
   endtask

   task rd_reg(input logic [11:0] ad, output logic [31:0] rd);
      logic er;
      apb(1'b0, ad, 32'h0000_0000, rd, er);
   endtask

   task wr_reg(input logic [11:0] ad, input logic [31:0] wd);
      logic [31:0] rd;
      logic        er;
      apb(1'b1, ad, wd, rd, er);
   endtask

   task pulse(input logic [4:0] m);
      @(posedge sys_clk);
      evt <= m;
      @(posedge sys_clk);
      evt <= 5'h00;
   endtask

   task wait_st(input oscg_state_t st);
      logic [31:0] rd;
      for (int i = 0; i < 60; i++)
      begin
         rd_reg(OSCG_STATUS_OFF, rd);
         if (rd[2:0] === st)
            break;
      end
      `CHK("state", st, rd[2:0])
   endtask

   task reset_dut(input logic [1:0] src, input logic sh);
      @(posedge sys_clk);
      srst      <= 1'b1;
      cfg_src   <= src;
      cfg_short <= sh;
      repeat (8) @(posedge sys_clk);
      `CHK("src_in_reset", OSCG_SRC_INTERNAL, clock_source_active)
      srst <= 1'b0;
      c0 = cpu_edges;
   endtask

   // Returns the cycles from wake to the first CPU clock edge.
   task stop_wake(output int cyc);
      logic [31:0] rd;
      int          base;
      pulse(EV_STOP);
      repeat (12) @(posedge sys_clk);
      rd_reg(OSCG_COUNT_OFF, rd);
      `CHK("count_stop", 32'h0000_0000, rd)
      base = per_edges;
      repeat (16) @(posedge sys_clk);
      `CHK("per_stop", 0, per_edges - base)
      pulse(EV_WAKE);
      base = cpu_edges;
      cyc = 0;
      while (cpu_edges == base && cyc < 300)
      begin
         @(posedge sys_clk);
         cyc++;
      end
   endtask

   initial
   begin
      repeat (20000) @(posedge sys_clk);
      error_cnt++;
      complete_run;
   end

   initial
   begin
      srst = 1'b1;
      cfg_src = OSCG_SRC_INTERNAL;
      cfg_short = 1'b1;
      evt = 5'h00;
      por = 1'b0;
      psel = 1'b0;
      penable = 1'b0;
      pwrite = 1'b0;
      paddr = 12'h000;
      pwdata = 32'h0000_0000;
      for (s = 0; s < 4; s++)
      begin
         reset_dut(s[1:0], 1'b1);
         n = 0;
         while (cpu_edges == c0 && n < 300)
         begin
            @(posedge sys_clk);
            n++;
         end
         `CHK("por_start", 1'b1, n >= 2 * P_POR && n <= 2 * P_POR + 24)
         `CHK("source", s[1:0], clock_source_active)
         c = cpu_edges;
         p = per_edges;
         q = quad_edges;
         repeat (64) @(posedge sys_clk);
         `CHK("quad_edges", 32, quad_edges - q)
         `CHK("cpu_edges", 8, cpu_edges - c)
         `CHK("per_edges", 8, per_edges - p)
         wr_reg(OSCG_CTRL_OFF, 32'h0000_0001);
         rd_reg(OSCG_CTRL_OFF, d);
         `CHK("ctrl", 32'h0000_0001, d)
         @(posedge sys_clk);
         `CHK("aux_oe", (s == 0 || s == 2), aux_clock_pin_oe)
         `CHK("aux_out", (s == 0 || s == 2) && quad_rate_clock, aux_clock_pin_out)
         a[0] = double_rate_clock;
         repeat (2) @(posedge sys_clk);
         `CHK("double_rate", ~a[0], double_rate_clock)
         wr_reg(OSCG_CTRL_OFF, 32'h0000_0000);
         // The pin select follows the enable bit one edge after the write lands.
         repeat (2) @(posedge sys_clk);
         `CHK("port_sel", (s == 0 || s == 2), port_bit_four_sel)
      end
      apb(1'b0, 12'h00c, 32'h0000_0000, d, e);
      `CHK("unmapped_err", 1'b1, e)
      `CHK("unmapped_data", 32'h0000_0000, d)
      pulse(EV_WAIT);
      repeat (12) @(posedge sys_clk);
      c = cpu_edges;
      p = per_edges;
      repeat (32) @(posedge sys_clk);
      `CHK("cpu_wait", 0, cpu_edges - c)
      `CHK("per_wait", 4, per_edges - p)
      pulse(EV_WAKE);
      wait_st(OSCG_ST_RUN);
      stop_wake(n);
      `CHK("short_rec", 1'b1, n >= 2 * P_SHORT && n <= 2 * P_SHORT + 24)
      reset_dut(OSCG_SRC_RC, 1'b0);
      wait_st(OSCG_ST_RUN);
      stop_wake(n);
      `CHK("long_rec", 1'b1, n >= 2 * P_LONG && n <= 2 * P_LONG + 24)
      pulse(EV_STOP);
      repeat (12) @(posedge sys_clk);
      pulse(EV_WAKE);
      repeat (10) @(posedge sys_clk);
      rd_reg(OSCG_COUNT_OFF, a);
      pulse(EV_XRST);
      rd_reg(OSCG_COUNT_OFF, b);
      `CHK("count_xrst", 1'b1, b > a)
      pulse(EV_IRST);
      rd_reg(OSCG_COUNT_OFF, d);
      `CHK("count_irst", 1'b1, d < b)
      @(posedge sys_clk);
      por <= 1'b1;
      @(posedge sys_clk);
      por <= 1'b0;
      rd_reg(OSCG_STATUS_OFF, d);
      `CHK("por_state", OSCG_ST_POR, d[2:0])
      c0 = cpu_edges;
      n = 0;
      while (cpu_edges == c0 && n < 300)
      begin
         @(posedge sys_clk);
         n++;
      end
      `CHK("por_restart", 1'b1, n >= 2 * P_POR && n <= 2 * P_POR + 24)
      complete_run;
   end
endmodule

/* sim/oscg_far_side.sv */
// Purpose: Far-side model of the clock consumers: CPU core, peripherals and timer.
// Assumes: The received clocks change only just after rising sys_clk edges.
// Notes:   Counts rising edges of each received clock for the bench to compare.
module oscg_far_side
(
   // Clock.
   input  wire logic sys_clk,
   // Clocks consumed.
   input  wire logic cpu_clock,
   input  wire logic periph_clock,
   input  wire logic quad_rate_clock,
   // Edge counts.
   output int        cpu_edges,
   output int        per_edges,
   output int        quad_edges
);
   timeunit 1ns;
   timeprecision 1ns;

   logic [2:0] prev_clk;

   initial
   begin
      cpu_edges  = 0;
      per_edges  = 0;
      quad_edges = 0;
      prev_clk   = 3'h0;
      forever
      begin
         @(posedge sys_clk);
         cpu_edges  <= cpu_edges + int'(cpu_clock && !prev_clk[0]);
         per_edges  <= per_edges + int'(periph_clock && !prev_clk[1]);
         quad_edges <= quad_edges + int'(quad_rate_clock && !prev_clk[2]);
         prev_clk   <= {quad_rate_clock, periph_clock, cpu_clock};
      end
   end
endmodule

/* src/oscg_clock_gating.sv */
// Purpose: Oscillator clock outputs, bus clock divider and CPU/peripheral clock gating.
// Assumes: srst acts as the power-on reset; the other inputs are synchronous to sys_clk.
// Notes:   Gated clocks change enable only at the end of a full bus clock period.
// What this block does
// - Output quad-rate and double-rate clocks.
// - Bus clock is half the double-rate clock.
// - Four selectable clock sources.
// - Internal oscillator selected during srst; straps set the source in the timeout.
// - Enable bit puts quad clock on pin.
// - Enable bit ignored for crystal or external.
// - Clocks held off during power-on timeout.
// - Bus clocks start right after timeout.
// - Quad clock drives counter during stop recovery.
// - Clocks off until 4096 or 32 cycles.
// - CPU clock gated off in wait.
// - Two clock sets; active modules keep clocking.
// - Peripheral clocks run during wait mode.
// - Counter held clear during stop mode.
// - Internal reset clears counter; external does not.
module oscg_clock_gating
   import oscg_pkg::*;
#(
   parameter int POR_QUAD_CYCLES   = OSCG_POR_TIMEOUT,
   parameter int STOP_LONG_CYCLES  = OSCG_STOP_LONG,
   parameter int STOP_SHORT_CYCLES = OSCG_STOP_SHORT
)
(
   // Clock and reset.
   input  wire logic                   sys_clk,
   input  wire logic                   srst,
   // Static configuration.
   input  wire logic [1:0]             cfg_clock_source,
   input  wire logic                   cfg_stop_short_delay,
   // Mode and reset events.
   input  wire logic                   por_reset,
   input  wire logic                   internal_reset,
   input  wire logic                   ext_reset_pin,
   input  wire logic                   wait_req,
   input  wire logic                   stop_req,
   input  wire logic                   wake_irq,
   // Generated clocks.
   output logic                        quad_rate_clock,
   output logic                        double_rate_clock,
   output logic                        cpu_clock,
   output logic                        periph_clock,
   output logic [1:0]                  clock_source_active,
   // Auxiliary pin.
   output logic                        aux_clock_pin_out,
   output logic                        aux_clock_pin_oe,
   output logic                        port_bit_four_sel,
   // APB slave.
   input  wire logic                   psel,
   input  wire logic                   penable,
   input  wire logic                   pwrite,
   input  wire logic [OSCG_ADDR_W-1:0] paddr,
   input  wire logic [31:0]            pwdata,
   output logic [31:0]                 prdata,
   output logic                        pready,
   output logic                        pslverr
);

   localparam logic [OSCG_CNT_W-1:0] POR_LAST   = OSCG_CNT_W'(POR_QUAD_CYCLES - 1);
   localparam logic [OSCG_CNT_W-1:0] LONG_LAST  = OSCG_CNT_W'(STOP_LONG_CYCLES - 1);
   localparam logic [OSCG_CNT_W-1:0] SHORT_LAST = OSCG_CNT_W'(STOP_SHORT_CYCLES - 1);

   typedef struct packed {
      logic [OSCG_PHASE_W-1:0] phase;
      oscg_state_t             fsm;
      logic [1:0]              src;
      logic                    clkout_en;
      logic                    cpu_on;
      logic                    per_on;
      logic                    cpu_clk;
      logic                    per_clk;
      logic                    aux_out;
      logic                    aux_oe;
      logic                    port_sel;
      logic [31:0]             prdata;
      logic                    pslverr;
   } oscg_main_t;

   oscg_main_t s;
   oscg_main_t next_s;

   logic [OSCG_CNT_W-1:0] count;
   logic                  tick;
   logic                  counting;
   logic                  done;
   logic                  cnt_clear;
   logic [OSCG_CNT_W-1:0] limit;
   logic                  setup;
   logic                  access;

   // A quad-rate cycle completes when its clock is high.
   assign tick     = s.phase[0];
   assign counting = (s.fsm == OSCG_ST_POR) || (s.fsm == OSCG_ST_RECOVER);
   assign limit    = (s.fsm == OSCG_ST_POR) ? POR_LAST :
                     (cfg_stop_short_delay ? SHORT_LAST : LONG_LAST);
   assign done     = counting && tick && (count == limit);
   // The reset pin alone never clears the counter.
   assign cnt_clear = internal_reset || por_reset || (s.fsm == OSCG_ST_STOP) || done;

   oscg_counter #(
      .WIDTH (OSCG_CNT_W)
   ) u_counter (
      .sys_clk (sys_clk),
      .srst    (srst),
      .clear   (cnt_clear),
      .tick    (tick),
      .count   (count)
   );

   assign setup  = psel && !penable;
   assign access = psel && penable;

   always_comb
   begin
      logic want_cpu;
      logic want_per;
      logic pin_shared;
      want_cpu   = 1'b0;
      want_per   = 1'b0;
      pin_shared = 1'b0;
      next_s       = s;
      next_s.phase = s.phase + OSCG_PHASE_W'(1);

      // Mode sequencing.
      if (por_reset)
      begin
         next_s.fsm = OSCG_ST_POR;
      end
      else
      begin
         case (s.fsm)
            OSCG_ST_POR:
            begin
               if (done)
               begin
                  next_s.fsm = OSCG_ST_RUN;
               end
            end
            OSCG_ST_RUN:
            begin
               if (stop_req)
               begin
                  next_s.fsm = OSCG_ST_STOP;
               end
               else if (wait_req)
               begin
                  next_s.fsm = OSCG_ST_WAIT;
               end
            end
            OSCG_ST_WAIT:
            begin
               if (wake_irq || internal_reset || ext_reset_pin)
               begin
                  next_s.fsm = OSCG_ST_RUN;
               end
            end
            OSCG_ST_STOP:
            begin
               if (wake_irq || internal_reset || ext_reset_pin)
               begin
                  next_s.fsm = OSCG_ST_RECOVER;
               end
            end
            OSCG_ST_RECOVER:
            begin
               if (done)
               begin
                  next_s.fsm = OSCG_ST_RUN;
               end
            end
            default:
            begin
               next_s.fsm = OSCG_ST_POR;
            end
         endcase
      end

      // Source is taken from the straps only while the power-on timeout runs.
      if (s.fsm == OSCG_ST_POR)
      begin
         next_s.src = cfg_clock_source;
      end

      case (s.fsm)
         OSCG_ST_RUN:
         begin
            want_cpu = 1'b1;
            want_per = 1'b1;
         end
         OSCG_ST_WAIT:
         begin
            want_per = 1'b1;
         end
         default:
         begin
            want_cpu = 1'b0;
         end
      endcase

      // Enables move only when the bus clock is about to start a low phase.
      if (s.phase == OSCG_PHASE_LAST)
      begin
         next_s.cpu_on = want_cpu;
         next_s.per_on = want_per;
      end
      next_s.cpu_clk = next_s.phase[2] && next_s.cpu_on;
      next_s.per_clk = next_s.phase[2] && next_s.per_on;

      // Auxiliary pin ownership.
      pin_shared      = (s.src == OSCG_SRC_INTERNAL) || (s.src == OSCG_SRC_RC);
      next_s.aux_oe   = pin_shared && s.clkout_en;
      next_s.port_sel = pin_shared && !s.clkout_en;
      next_s.aux_out  = next_s.aux_oe && next_s.phase[0];

      // APB: data is captured in the setup cycle and presented during access.
      if (setup)
      begin
         next_s.pslverr = 1'b0;
         next_s.prdata  = OSCG_ZERO_WORD;
         if (paddr == OSCG_CTRL_OFF)
         begin
            next_s.prdata[OSCG_CTRL_CLKOUT_BIT] = s.clkout_en;
         end
         else if (paddr == OSCG_STATUS_OFF)
         begin
            next_s.prdata[OSCG_STAT_STATE_LSB +: 3] = s.fsm;
            next_s.prdata[OSCG_STAT_SRC_LSB +: 2]   = s.src;
            next_s.prdata[OSCG_STAT_CPU_BIT]        = s.cpu_on;
            next_s.prdata[OSCG_STAT_PER_BIT]        = s.per_on;
         end
         else if (paddr == OSCG_COUNT_OFF)
         begin
            next_s.prdata[OSCG_CNT_W-1:0] = count;
         end
         else
         begin
            next_s.pslverr = 1'b1;
         end
      end
      if (access && pwrite && (paddr == OSCG_CTRL_OFF))
      begin
         next_s.clkout_en = pwdata[OSCG_CTRL_CLKOUT_BIT];
      end
   end

   always_ff @(posedge sys_clk)
   begin
      if (srst)
      begin
         s           <= '0;
         s.fsm       <= OSCG_ST_POR;
         s.src       <= OSCG_SRC_INTERNAL;
         s.clkout_en <= OSCG_CLKOUT_RST;
      end
      else
      begin
         s <= next_s;
      end
   end

   assign quad_rate_clock     = s.phase[0];
   assign double_rate_clock   = s.phase[1];
   assign cpu_clock           = s.cpu_clk;
   assign periph_clock        = s.per_clk;
   assign clock_source_active = s.src;
   assign aux_clock_pin_out   = s.aux_out;
   assign aux_clock_pin_oe    = s.aux_oe;
   assign port_bit_four_sel   = s.port_sel;
   assign prdata              = s.prdata;
   assign pready              = access;
   assign pslverr             = access && s.pslverr;

   sequence s_por_done;
      (s.fsm == OSCG_ST_POR) && done && !por_reset;
   endsequence

   sequence s_cpu_starts;
      ##[1:9] s.cpu_on;
   endsequence

   property p_quad_toggles;
      @(posedge sys_clk) disable iff (srst)
      // The first edge after reset still sees the held-low reset value on both sides.
      !$past(srst) |-> quad_rate_clock != $past(quad_rate_clock);
   endproperty
   a_quad_toggles: assert property (p_quad_toggles) else $error("quad clock stalled");

   property p_bus_half;
      @(posedge sys_clk) disable iff (srst)
      $changed(s.phase[2]) |-> $fell(double_rate_clock);
   endproperty
   a_bus_half: assert property (p_bus_half) else $error("bus clock not half of double");

   property p_reset_internal;
      @(posedge sys_clk)
      srst |=> (clock_source_active == OSCG_SRC_INTERNAL);
   endproperty
   a_reset_internal: assert property (p_reset_internal) else $error("source not internal");

   property p_aux_clock;
      @(posedge sys_clk) disable iff (srst)
      aux_clock_pin_oe |-> (aux_clock_pin_out == quad_rate_clock) && !port_bit_four_sel;
   endproperty
   a_aux_clock: assert property (p_aux_clock) else $error("aux pin not quad clock");

   property p_aux_ignored;
      @(posedge sys_clk) disable iff (srst)
      ($past(s.src) == OSCG_SRC_CRYSTAL || $past(s.src) == OSCG_SRC_EXTERNAL)
      |-> !aux_clock_pin_oe && !port_bit_four_sel;
   endproperty
   a_aux_ignored: assert property (p_aux_ignored) else $error("enable acted on crystal");

   property p_por_hold;
      @(posedge sys_clk) disable iff (srst)
      (s.fsm == OSCG_ST_POR) && $past(s.fsm == OSCG_ST_POR, 8) |-> !cpu_clock && !periph_clock;
   endproperty
   a_por_hold: assert property (p_por_hold) else $error("clock ran in por timeout");

   property p_por_start;
      @(posedge sys_clk) disable iff (srst || por_reset || stop_req || wait_req)
      s_por_done |-> s_cpu_starts;
   endproperty
   a_por_start: assert property (p_por_start) else $error("clocks late after timeout");

   property p_recover_off;
      @(posedge sys_clk) disable iff (srst)
      (s.fsm == OSCG_ST_RECOVER) && $past(s.fsm == OSCG_ST_RECOVER, 8) |-> !cpu_clock;
   endproperty
   a_recover_off: assert property (p_recover_off) else $error("cpu clock in recovery");

   property p_wait_gate;
      @(posedge sys_clk) disable iff (srst)
      (s.fsm == OSCG_ST_WAIT) [*8] ##1 (s.fsm == OSCG_ST_WAIT) |-> !cpu_clock && s.per_on;
   endproperty
   a_wait_gate: assert property (p_wait_gate) else $error("wait gating wrong");

   property p_stop_clear;
      @(posedge sys_clk) disable iff (srst)
      $past(s.fsm == OSCG_ST_STOP) && (s.fsm == OSCG_ST_STOP) |-> count == '0;
   endproperty
   a_stop_clear: assert property (p_stop_clear) else $error("counter ran in stop");

   property p_int_reset;
      @(posedge sys_clk) disable iff (srst)
      internal_reset |=> count == '0;
   endproperty
   a_int_reset: assert property (p_int_reset) else $error("internal reset kept count");

   property p_glitch_free;
      @(posedge sys_clk) disable iff (srst)
      ($changed(s.cpu_on) || $changed(s.per_on)) |-> (s.phase == '0) && !cpu_clock;
   endproperty
   a_glitch_free: assert property (p_glitch_free) else $error("gate moved mid phase");

endmodule

/* src/oscg_counter.sv */
// Purpose: Timing counter clocked by quad-rate ticks.
// Assumes: tick is high for one sys_clk cycle per quad-rate cycle.
// Notes:   clear has priority over tick; srst also clears.
module oscg_counter
   import oscg_pkg::*;
#(
   parameter int WIDTH = OSCG_CNT_W
)
(
   // Clock and reset.
   input  wire logic             sys_clk,
   input  wire logic             srst,
   // Control.
   input  wire logic             clear,
   input  wire logic             tick,
   // Value.
   output logic [WIDTH-1:0]      count
);

   typedef struct packed {
      logic [WIDTH-1:0] count;
   } oscg_cnt_t;

   oscg_cnt_t s;
   oscg_cnt_t next_s;

   always_comb
   begin
      next_s = s;
      if (clear)
      begin
         next_s.count = '0;
      end
      else if (tick)
      begin
         next_s.count = s.count + WIDTH'(1);
      end
   end

   always_ff @(posedge sys_clk)
   begin
      if (srst)
      begin
         s <= '0;
      end
      else
      begin
         s <= next_s;
      end
   end

   assign count = s.count;

endmodule

/* src/oscg_pkg.sv */
// Purpose: Shared constants and types for the oscillator and clock gating block.
// Assumes: sys_clk is the raw oscillator clock; one quad-rate cycle spans two sys_clk cycles.
// Notes:   Register offsets are byte addresses on a 32-bit APB bus.
package oscg_pkg;

   // Clock source encodings.
   localparam logic [1:0] OSCG_SRC_INTERNAL = 2'h0;
   localparam logic [1:0] OSCG_SRC_EXTERNAL = 2'h1;
   localparam logic [1:0] OSCG_SRC_RC       = 2'h2;
   localparam logic [1:0] OSCG_SRC_CRYSTAL  = 2'h3;

   // Timeouts in quad-rate clock cycles.
   localparam int OSCG_POR_TIMEOUT    = 4096;
   localparam int OSCG_STOP_LONG      = 4096;
   localparam int OSCG_STOP_SHORT     = 32;
   localparam int OSCG_CNT_W          = 13;

   // Phase counter: bit 0 is the quad-rate clock, bit 1 double-rate, bit 2 bus clock.
   localparam int         OSCG_PHASE_W    = 3;
   localparam logic [2:0] OSCG_PHASE_LAST = 3'h7;

   // APB register map.
   localparam int          OSCG_ADDR_W     = 12;
   localparam logic [11:0] OSCG_CTRL_OFF   = 12'h000;
   localparam logic [11:0] OSCG_STATUS_OFF = 12'h004;
   localparam logic [11:0] OSCG_COUNT_OFF  = 12'h008;

   // Field positions.
   localparam int OSCG_CTRL_CLKOUT_BIT  = 0;
   localparam int OSCG_STAT_STATE_LSB   = 0;
   localparam int OSCG_STAT_SRC_LSB     = 3;
   localparam int OSCG_STAT_CPU_BIT     = 5;
   localparam int OSCG_STAT_PER_BIT     = 6;

   // Reset values.
   localparam logic        OSCG_CLKOUT_RST = 1'h0;
   localparam logic [31:0] OSCG_ZERO_WORD  = 32'h0000_0000;

   typedef enum logic [2:0] {
      OSCG_ST_POR     = 3'h0,
      OSCG_ST_RUN     = 3'h1,
      OSCG_ST_WAIT    = 3'h2,
      OSCG_ST_STOP    = 3'h3,
      OSCG_ST_RECOVER = 3'h4
   } oscg_state_t;

endpackage
